// [hw/gpt_params.svh]
/*
 * Constants of the general purpose down timer: register offsets, field positions,
 * reset values and widths, as `define macros.
 * Assumes inclusion by bare name from the timer design files.
 */
`ifndef GPT_PARAMS_SVH
`define GPT_PARAMS_SVH

`define GPT_CNT_W          13
`define GPT_CODEC_W        12
`define GPT_CLK_PERIOD_NS  100
`define GPT_CLK_DIV        2

`define GPT_CTRL_OFF       12'h000
`define GPT_STAT_OFF       12'h004
`define GPT_CNTR_OFF       12'h008
`define GPT_CDIV_OFF       12'h00c

`define GPT_CTRL_CNT_LSB   0
`define GPT_CTRL_SRC_BIT   13
`define GPT_CTRL_RUN_BIT   14
`define GPT_CTRL_DIS_BIT   15
`define GPT_CTRL_ONE_BIT   16

`define GPT_STAT_EN_BIT    0
`define GPT_STAT_RUN_BIT   1
`define GPT_STAT_IRQ_BIT   2
`define GPT_STAT_PIN_BIT   3

`define GPT_CTRL_RST       32'h0000_0000
`define GPT_CDIV_RST       12'h001

`endif

// [hw/gpt_pkg.sv]
/*
 * Types of the general purpose down timer: control fields and run state.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gpt_pkg;

   typedef enum logic [1:0] {
      GPT_STOPPED    = 2'b00,
      GPT_CONTINUOUS = 2'b01,
      GPT_ONE_SHOT   = 2'b10
   } gpt_mode_e;

   typedef enum logic {
      GPT_SRC_CLK_DIV2 = 1'b0,
      GPT_SRC_CODEC    = 1'b1
   } gpt_src_e;

   typedef struct packed {
      logic        one_shot;
      logic        disable_req;
      logic        run;
      gpt_src_e    src;
      logic [12:0] count;
   } gpt_ctrl_s;

endpackage

// [hw/gpt_tick_gen.sv]
/*
 * Tick source of the down timer: a divide-by-two of the system clock and a
 * 12-bit codec counter/timer model that divides the system clock by a programmed
 * period. Assumes a single synchronous clock and active-low synchronous reset.
 */
`timescale 1ns/100ps
`include "gpt_params.svh"

module gpt_tick_gen #(
   parameter int CODEC_W = `GPT_CODEC_W
) (
   input  wire logic               ref_clk_i,
   input  wire logic               rstn_i,
   input  wire gpt_pkg::gpt_src_e  src_i,
   input  wire logic [CODEC_W-1:0] codec_period_i,
   output logic                    tick_o
);

   logic               div2_q;
   logic [CODEC_W-1:0] codec_cnt_q;
   logic [CODEC_W-1:0] codec_cnt_d;
   logic               codec_wrap;

   // A period of zero is treated as one so the codec path never stalls for good.
   assign codec_wrap  = (codec_cnt_q == '0);
   assign codec_cnt_d = codec_wrap ? ((codec_period_i == '0) ? '0 : codec_period_i - 1'b1)
                                   : codec_cnt_q - 1'b1;
   assign tick_o      = (src_i == gpt_pkg::GPT_SRC_CODEC) ? codec_wrap : div2_q;

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         div2_q      <= 1'b0;
         codec_cnt_q <= '0;
      end else begin
         div2_q      <= ~div2_q;
         codec_cnt_q <= codec_cnt_d;
      end
   end

endmodule

// [hw/gpt_timer.sv]
/*
 * General purpose 13-bit down timer with an APB register slave, continuous and
 * one-shot modes, a one-way disable and a shared timer interrupt line.
 * Assumes a 10 MHz system clock, active-low synchronous reset, and that the
 * interrupt pin input already carries the pull-down resolved level.
 */
`timescale 1ns/100ps
`include "gpt_params.svh"

// Summary of operation
// - Timer comes out of every reset enabled.
// - Once disabled, enabling is ignored until the next reset.
// - The count is a thirteen-bit down-counter.
// - Continuous, one-shot and stopped states are supported.
// - In run mode each arrival at zero raises the timer interrupt.
// - Continuous mode reloads the programmed count at zero and keeps going.
// - One-shot handler clears control bit fourteen; counting then stops.
// - System clock over two gives count times two clock periods.
// - Codec source decrements once per codec period, 25-bit interval.
// - After reset the timer is enabled but stopped.
// - While enabled, the interrupt goes out on the timer interrupt vector.
// - The timer interrupt pin has an internal pull-down.
// - When disabled, the external pin alone drives the interrupt.
module gpt_timer #(
   parameter int CNT_W   = `GPT_CNT_W,
   parameter int CODEC_W = `GPT_CODEC_W
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        timer_interrupt_line_i,
   output logic             timer_interrupt_line_o,
   output logic             timer_interrupt_line_oe,
   output logic             timer_pulldown_en_o,
   output logic             timer_irq_o,
   output logic             timer_enabled_o
);

   gpt_pkg::gpt_ctrl_s  ctrl_q;
   gpt_pkg::gpt_ctrl_s  ctrl_wr;
   gpt_pkg::gpt_mode_e  mode;
   logic [CNT_W-1:0]    cnt_q;
   logic [CNT_W-1:0]    cnt_d;
   logic [CODEC_W-1:0]  cdiv_q;
   logic                enabled_q;
   logic                irq_q;
   logic                zero_hit;
   logic                tick;
   logic                running;
   logic                wr_en;
   logic                rd_en;
   logic                sel_ctrl;
   logic                sel_stat;
   logic                sel_cntr;
   logic                sel_cdiv;
   logic                addr_ok;
   logic                load;
   logic [31:0]         rd_mux;

   function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
      addr_is = (a == off);
   endfunction

   assign sel_ctrl = addr_is(paddr, `GPT_CTRL_OFF);
   assign sel_stat = addr_is(paddr, `GPT_STAT_OFF);
   assign sel_cntr = addr_is(paddr, `GPT_CNTR_OFF);
   assign sel_cdiv = addr_is(paddr, `GPT_CDIV_OFF);
   assign addr_ok  = sel_ctrl | sel_stat | sel_cntr | sel_cdiv;

   // Zero-wait slave: every access completes in its first access cycle.
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign wr_en   = psel & penable & pwrite & addr_ok;
   assign rd_en   = psel & penable & ~pwrite;

   assign ctrl_wr = gpt_pkg::gpt_ctrl_s'(pwdata[16:0]);
   assign load    = wr_en & sel_ctrl & enabled_q;

   assign mode = !ctrl_q.run ? gpt_pkg::GPT_STOPPED :
                 (ctrl_q.one_shot ? gpt_pkg::GPT_ONE_SHOT : gpt_pkg::GPT_CONTINUOUS);
   assign running  = enabled_q & (mode != gpt_pkg::GPT_STOPPED) & (ctrl_q.count != '0);
   assign zero_hit = running & tick & (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});

   // Count reaches zero on this tick; reload happens in the same step so the period is exact.
   always_comb begin
      cnt_d = cnt_q;
      if (load) begin
         cnt_d = ctrl_wr.count;
      end else if (running & tick) begin
         if (zero_hit) begin
            cnt_d = ctrl_q.count;
         end else begin
            cnt_d = cnt_q - 1'b1;
         end
      end
   end

   gpt_tick_gen #(
      .CODEC_W (CODEC_W)
   ) u_tick (
      .ref_clk_i      (ref_clk_i),
      .rstn_i         (rstn_i),
      .src_i          (ctrl_q.src),
      .codec_period_i (cdiv_q),
      .tick_o         (tick)
   );

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         enabled_q <= 1'b1;
         ctrl_q    <= gpt_pkg::gpt_ctrl_s'(`GPT_CTRL_RST);
         cnt_q     <= '0;
         cdiv_q    <= `GPT_CDIV_RST;
         irq_q     <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         if (wr_en & sel_cdiv) begin
            cdiv_q <= pwdata[CODEC_W-1:0];
         end
         if (load) begin
            ctrl_q <= ctrl_wr;
            if (ctrl_wr.disable_req) begin
               enabled_q <= 1'b0;
            end
         end
         // One-shot: after zero the counter keeps reloading until software clears run.
         irq_q <= zero_hit;
      end
   end

   // The timer only ever drives the line high; released when disabled.
   assign timer_interrupt_line_o  = irq_q;
   assign timer_interrupt_line_oe = enabled_q & irq_q;
   assign timer_pulldown_en_o     = 1'b1;
   assign timer_irq_o = enabled_q ? irq_q : timer_interrupt_line_i;
   assign timer_enabled_o = enabled_q;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (sel_ctrl) begin
         rd_mux[16:0] = ctrl_q;
      end else if (sel_stat) begin
         rd_mux[`GPT_STAT_EN_BIT]  = enabled_q;
         rd_mux[`GPT_STAT_RUN_BIT] = running;
         rd_mux[`GPT_STAT_IRQ_BIT] = irq_q;
         rd_mux[`GPT_STAT_PIN_BIT] = timer_interrupt_line_i;
      end else if (sel_cntr) begin
         rd_mux[CNT_W-1:0] = cnt_q;
      end else if (sel_cdiv) begin
         rd_mux[CODEC_W-1:0] = cdiv_q;
      end
   end

   assign prdata = rd_en ? rd_mux : 32'h0000_0000;

endmodule

// [tb/gpt_timer_props.sv]
/* Checker on the timer's enable and interrupt pins.
   Bound to gpt_timer; it sees the ports of that module only. */
`timescale 1ns/100ps
module gpt_timer_props #(parameter int CNT_W = 13, parameter int CODEC_W = 12) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic timer_interrupt_line_i,
   input wire logic timer_interrupt_line_o,
   input wire logic timer_interrupt_line_oe,
   input wire logic timer_pulldown_en_o,
   input wire logic timer_irq_o,
   input wire logic timer_enabled_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   property p_en_rst; $rose(rstn_i) |-> timer_enabled_o; endproperty
   a_en_rst: assert property (p_en_rst) else $error("not enabled after reset");
   property p_stop_rst; $rose(rstn_i) |-> !timer_irq_o [*3]; endproperty
   a_stop_rst: assert property (p_stop_rst) else $error("irq right after reset");
   property p_sticky; !timer_enabled_o |=> !timer_enabled_o; endproperty
   a_sticky: assert property (p_sticky) else $error("timer enabled again");
   property p_pull; timer_pulldown_en_o; endproperty
   a_pull: assert property (p_pull) else $error("pull-down off");
   property p_rel; !timer_enabled_o |-> !timer_interrupt_line_oe; endproperty
   a_rel: assert property (p_rel) else $error("pin driven while disabled");
   property p_ext; !timer_enabled_o |-> timer_irq_o == timer_interrupt_line_i; endproperty
   a_ext: assert property (p_ext) else $error("irq not from pin");
   property p_own; timer_enabled_o |-> timer_irq_o == timer_interrupt_line_o; endproperty
   a_own: assert property (p_own) else $error("irq not from timer");
   property p_drv; timer_interrupt_line_oe |-> timer_interrupt_line_o; endproperty
   a_drv: assert property (p_drv) else $error("pin driven low");
endmodule
bind gpt_timer gpt_timer_props #(.CNT_W(CNT_W), .CODEC_W(CODEC_W)) props_u (.*);

// [tb/gpt_pin_model.sv]
/* Interrupt pin: the timer, an external peripheral and the pull-down.
   Assumes the timer's drive value and enable at its ports. */
`timescale 1ns/100ps
module gpt_pin_model (
   input  wire logic dev_oe_i,
   input  wire logic dev_val_i,
   input  wire logic ext_en_i,
   input  wire logic ext_val_i,
   output logic      pin_o
);
   // A released pin settles at the pull-down level, never at its last value.
   assign pin_o = dev_oe_i ? dev_val_i : (ext_en_i ? ext_val_i : 1'b0);
endmodule

// [tb/gpt_timer_bench.sv]
/* Self-checking bench of the down timer over APB with an interrupt pin model.
   Assumes gpt_timer and gpt_pin_model are compiled first. */
`timescale 1ns/100ps
module gpt_timer_bench;
   logic        ref_clk_i, rstn_i, psel, penable, pwrite, pready, pslverr, err;
   logic        pin, dev_o, dev_oe, ext_en, ext_val, irq, en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          failures, cmp_count, cyc;

   gpt_timer dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_interrupt_line_i(pin), .timer_interrupt_line_o(dev_o),
      .timer_interrupt_line_oe(dev_oe), .timer_pulldown_en_o(), .timer_irq_o(irq),
      .timer_enabled_o(en));
   gpt_pin_model pin_u (.dev_oe_i(dev_oe), .dev_val_i(dev_o), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .pin_o(pin));

   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         complete_run();
      end
   end

   task complete_run();
      if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      penable <= 1'b1;
      do @(posedge ref_clk_i); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Counts clocks from one interrupt pulse to the next.
   task gap(input int exp);
      int n;
      n = 0;
      @(negedge ref_clk_i iff irq === 1'b1);
      do begin
         @(negedge ref_clk_i);
         n++;
      end while (irq !== 1'b1);
      chk(n, exp);
   endtask

   task t_reset();
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0000_0001);
      apb(1'b0, 12'h010, 32'h0);
      chk(err, 1'b1);
   endtask
   task t_cont();
      apb(1'b1, 12'h000, 32'h0000_4003);
      gap(6);
      gap(6);
   endtask
   task t_codec();
      apb(1'b1, 12'h00c, 32'h0000_0004);
      apb(1'b1, 12'h000, 32'h0000_6002);
      // A pulse left over from the previous setting may still arrive; skip one.
      @(negedge ref_clk_i iff irq === 1'b1);
      gap(8);
   endtask
   task t_stop();
      int k;
      k = 0;
      apb(1'b1, 12'h000, 32'h0001_4002);
      @(negedge ref_clk_i iff irq === 1'b1);
      gap(4);
      apb(1'b1, 12'h000, 32'h0001_0002);
      repeat (3) @(negedge ref_clk_i);
      repeat (40) @(negedge ref_clk_i) if (irq !== 1'b0) k++;
      chk(k, 0);
   endtask
   task t_disable();
      ext_en  <= 1'b1;
      ext_val <= 1'b1;
      apb(1'b1, 12'h000, 32'h0000_c003);
      apb(1'b1, 12'h000, 32'h0000_4003);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd & 32'h9, 32'h8);
      ext_val <= 1'b0;
      @(negedge ref_clk_i);
      chk(irq, 1'b0);
      @(posedge ref_clk_i);
      ext_val <= 1'b1;
      @(negedge ref_clk_i);
      chk(irq, 1'b1);
      @(posedge ref_clk_i);
      ext_en <= 1'b0;
      @(negedge ref_clk_i);
      chk(irq, 1'b0);
      @(posedge ref_clk_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0000_0001);
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata, ext_en, ext_val, rstn_i} = '0;
      failures = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (20) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      t_reset();
      t_cont();
      t_codec();
      t_stop();
      t_disable();
      complete_run();
   end
endmodule
